// ===== ata_write_params.svh
`ifndef ATA_WRITE_PARAMS_SVH
`define ATA_WRITE_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define AW_OFF_DATA 4'h0
`define AW_OFF_FEAT 4'h1
`define AW_OFF_SECCNT 4'h2
`define AW_OFF_SECNUM 4'h3
`define AW_OFF_TRKLO 4'h4
`define AW_OFF_TRKHI 4'h5
`define AW_OFF_DRVHD 4'h6
`define AW_OFF_CMD 4'h7
`define AW_OFF_BLKSZ 4'h8
`define AW_OFF_IRQST 4'h9
`define AW_OFF_IRQMASK 4'ha

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define AW_CMD_WRSEC_A 8'h30
`define AW_CMD_WRSEC_B 8'h31
`define AW_CMD_WRSEC_NE 8'h38
`define AW_CMD_WRMULT 8'hc5
`define AW_CMD_WRMULT_NE 8'hcd

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define AW_ST_BUSY 7
`define AW_ST_READY 6
`define AW_ST_DRQ 3
`define AW_ST_ERR 0
`define AW_ER_ABRT 2
`define AW_ER_IDNF 4
`define AW_IRQ_BLK 0
`define AW_IRQ_DONE 1
`define AW_IRQ_ERR 2
`define AW_BLK_EN 8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define AW_SECCNT_RST 8'h01
`define AW_SECNUM_RST 8'h01
`define AW_BLKSZ_RST 8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define AW_CLK_NS 4
`define AW_BSY_MAX_NS 400
`define AW_BSY_MAX_CYC ((`AW_BSY_MAX_NS) / (`AW_CLK_NS))

`endif

// ===== ata_write_pkg.sv
package ata_write_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_XFER,
    ST_PROG,
    ST_WAITM
  } state_e;

endpackage : ata_write_pkg

// ===== sector_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module sector_buffer #(
  parameter int DW = 16,
  parameter int DEPTH = 2048,
  parameter int AW = 11
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : sector_buffer

`default_nettype wire

// ===== ata_write_command_engine.sv
// What this block does
// - code c5h is block write; block size one always allowed, larger optional
// - busy raised within 400 ns of accepting a block write
// - block writes interrupt once per block, never between its sectors
// - data request qualifies only block start; no recheck between sectors
// - count register counts sectors; full blocks then one remainder block
// - block write without block size or while disabled is aborted
// - error posted after the attempted write; stop at failing sector
// - block interrupt raised together with data request at each block start except the first
// - on error address holds failing sector, count holds sectors still needed
// - code cdh is block write without the implied erase
// - codes 30h/31h write 1 to 256 sectors; zero count means 256
// - logical address from head, high track, low track, start sector
// - accept: busy, then data request and busy clear; no first interrupt
// - per sector: busy, drop request; buffer ready: clear, request, interrupt
// - after last data busy holds until done, then completion interrupt
// - multi-sector error stops there; address registers keep that sector
// - code 38h is sector write without implied erase
//
// Strobed register access was left to the implementer.
`include "ata_write_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ata_write_command_engine #(
  parameter int MAX_BLOCK = 8,
  parameter int WORDS_PER_SECTOR = 256
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  output logic intrq,
  output logic busy,
  output logic dataReq,
  output logic mediaValid,
  output logic [15:0] mediaData,
  output logic mediaLast,
  output logic [27:0] mediaLba,
  output logic mediaErase,
  input wire logic mediaDone,
  input wire logic mediaErr
);

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int SIW = (MAX_BLOCK > 1) ? $clog2(MAX_BLOCK) : 1;
  localparam int WW = $clog2(WORDS_PER_SECTOR);
  localparam int BAW = SIW + WW;
  localparam logic [WW-1:0] LAST_WORD = WW'(WORDS_PER_SECTOR - 1);
  localparam logic [7:0] MAX_BLK = 8'(MAX_BLOCK);

  typedef struct packed {
    ata_write_pkg::state_e st;
    logic [7:0] feat;
    logic [7:0] secCnt;
    logic [7:0] secNum;
    logic [7:0] trkLo;
    logic [7:0] trkHi;
    logic [7:0] drvHd;
    logic [7:0] errReg;
    logic [7:0] blkSize;
    logic multEn;
    logic busy;
    logic drq;
    logic errSt;
    logic [2:0] irqSt;
    logic [2:0] irqMask;
    logic intrq;
    logic [15:0] rdData;
    logic [8:0] remain;
    logic [27:0] lba;
    logic multi;
    logic noErase;
    logic [SIW:0] xferSecs;
    logic [SIW-1:0] secIdx;
    logic [WW-1:0] wordCnt;
    logic mVal;
    logic mLast;
    logic [27:0] mLba;
    logic mErase;
  } state_s;

  state_s q;
  state_s n;

  logic memWe;
  logic memRe;
  logic [BAW-1:0] memAddr;
  logic cmdGo;
  logic isSingle;
  logic isMulti;
  logic [2:0] irqSet;
  logic [2:0] irqClr;
  logic [8:0] remNext;
  logic [27:0] lbaNext;

  // ------------------------------------------------------------
  // block size for the next transfer
  // ------------------------------------------------------------
  function automatic logic [SIW:0] blockFor(input logic multi, input logic [7:0] bs,
                                            input logic [8:0] rem);
    logic [8:0] b;
    b = {1'b0, bs};
    if (!multi) begin
      blockFor = (SIW+1)'(1);
    end else if (rem < b) begin
      blockFor = (SIW+1)'(rem);
    end else begin
      blockFor = (SIW+1)'(b);
    end
  endfunction : blockFor

  // ------------------------------------------------------------
  // sector buffer
  // ------------------------------------------------------------
  assign memAddr = {q.secIdx, q.wordCnt};

  sector_buffer #(
    .DW(16),
    .DEPTH(MAX_BLOCK * WORDS_PER_SECTOR),
    .AW(BAW)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .wrEn(memWe),
    .wrAddr(memAddr),
    .wrData(regWrData),
    .rdEn(memRe),
    .rdAddr(memAddr),
    .rdData(mediaData)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    memWe = 1'b0;
    memRe = 1'b0;
    irqSet = 3'h0;
    irqClr = 3'h0;
    n.mVal = 1'b0;
    n.mLast = 1'b0;
    remNext = q.remain - 9'h001;
    lbaNext = q.lba + 28'h0000001;
    cmdGo = 1'b0;
    isSingle = (regWrData[7:0] == `AW_CMD_WRSEC_A) || (regWrData[7:0] == `AW_CMD_WRSEC_B) ||
               (regWrData[7:0] == `AW_CMD_WRSEC_NE);
    isMulti = (regWrData[7:0] == `AW_CMD_WRMULT) || (regWrData[7:0] == `AW_CMD_WRMULT_NE);

    // register writes; task file frozen while a command runs
    if (regWr) begin
      case (regAddr)
        `AW_OFF_FEAT: begin
          if (q.st == ata_write_pkg::ST_IDLE) n.feat = regWrData[7:0];
        end
        `AW_OFF_SECCNT: begin
          if (q.st == ata_write_pkg::ST_IDLE) n.secCnt = regWrData[7:0];
        end
        `AW_OFF_SECNUM: begin
          if (q.st == ata_write_pkg::ST_IDLE) n.secNum = regWrData[7:0];
        end
        `AW_OFF_TRKLO: begin
          if (q.st == ata_write_pkg::ST_IDLE) n.trkLo = regWrData[7:0];
        end
        `AW_OFF_TRKHI: begin
          if (q.st == ata_write_pkg::ST_IDLE) n.trkHi = regWrData[7:0];
        end
        `AW_OFF_DRVHD: begin
          if (q.st == ata_write_pkg::ST_IDLE) n.drvHd = regWrData[7:0];
        end
        `AW_OFF_CMD: begin
          cmdGo = (q.st == ata_write_pkg::ST_IDLE);
        end
        `AW_OFF_BLKSZ: begin
          if (q.st == ata_write_pkg::ST_IDLE) begin
            // unsupported sizes leave block mode unprogrammed
            if (regWrData[7:0] != 8'h00 && regWrData[7:0] <= MAX_BLK) begin
              n.blkSize = regWrData[7:0];
            end else begin
              n.blkSize = 8'h00;
            end
            n.multEn = regWrData[`AW_BLK_EN];
          end
        end
        `AW_OFF_IRQST: begin
          irqClr = regWrData[2:0];
        end
        `AW_OFF_IRQMASK: begin
          n.irqMask = regWrData[2:0];
        end
        default: begin
        end
      endcase
    end

    // command sequencer
    case (q.st)
      ata_write_pkg::ST_IDLE: begin
        if (cmdGo) begin
          n.errReg = 8'h00;
          n.errSt = 1'b0;
          if (!(isSingle || isMulti) ||
              (isMulti && (q.blkSize == 8'h00 || !q.multEn))) begin
            n.errReg[`AW_ER_ABRT] = 1'b1;
            n.errSt = 1'b1;
            irqSet[`AW_IRQ_ERR] = 1'b1;
          end else begin
            n.busy = 1'b1;
            n.st = ata_write_pkg::ST_START;
            n.multi = isMulti;
            n.noErase = (regWrData[7:0] == `AW_CMD_WRSEC_NE) ||
                        (regWrData[7:0] == `AW_CMD_WRMULT_NE);
            n.remain = (q.secCnt == 8'h00) ? 9'h100 : {1'b0, q.secCnt};
            n.lba = {q.drvHd[3:0], q.trkHi, q.trkLo, q.secNum};
          end
        end
      end
      ata_write_pkg::ST_START: begin
        // first block opens without an interrupt
        n.busy = 1'b0;
        n.drq = 1'b1;
        n.xferSecs = blockFor(q.multi, q.blkSize, q.remain);
        n.secIdx = '0;
        n.wordCnt = '0;
        n.st = ata_write_pkg::ST_XFER;
      end
      ata_write_pkg::ST_XFER: begin
        // data words only taken while the request stands
        if (regWr && regAddr == `AW_OFF_DATA) begin
          // whole block streams in with no per-sector handshake
          memWe = 1'b1;
          n.wordCnt = q.wordCnt + 1'b1;
          if (q.wordCnt == LAST_WORD) begin
            if ({1'b0, q.secIdx} == q.xferSecs - 1'b1) begin
              n.busy = 1'b1;
              n.drq = 1'b0;
              n.secIdx = '0;
              n.st = ata_write_pkg::ST_PROG;
              n.mLba = q.lba;
              n.mErase = !q.noErase;
              {n.drvHd[3:0], n.trkHi, n.trkLo, n.secNum} = q.lba;
            end else begin
              n.secIdx = q.secIdx + 1'b1;
            end
          end
        end
      end
      ata_write_pkg::ST_PROG: begin
        memRe = 1'b1;
        n.mVal = 1'b1;
        n.mLast = (q.wordCnt == LAST_WORD);
        n.wordCnt = q.wordCnt + 1'b1;
        if (q.wordCnt == LAST_WORD) begin
          n.st = ata_write_pkg::ST_WAITM;
        end
      end
      ata_write_pkg::ST_WAITM: begin
        if (mediaDone) begin
          if (mediaErr) begin
            // address already names the failing sector
            n.busy = 1'b0;
            n.errSt = 1'b1;
            n.errReg[`AW_ER_IDNF] = 1'b1;
            n.secCnt = q.remain[7:0];
            irqSet[`AW_IRQ_ERR] = 1'b1;
            n.st = ata_write_pkg::ST_IDLE;
          end else begin
            n.remain = remNext;
            n.lba = lbaNext;
            if (remNext == 9'h000) begin
              n.busy = 1'b0;
              n.secCnt = 8'h00;
              irqSet[`AW_IRQ_DONE] = 1'b1;
              n.st = ata_write_pkg::ST_IDLE;
            end else if ({1'b0, q.secIdx} != q.xferSecs - 1'b1) begin
              n.secIdx = q.secIdx + 1'b1;
              n.wordCnt = '0;
              n.mLba = lbaNext;
              {n.drvHd[3:0], n.trkHi, n.trkLo, n.secNum} = lbaNext;
              n.st = ata_write_pkg::ST_PROG;
            end else begin
              n.busy = 1'b0;
              n.drq = 1'b1;
              irqSet[`AW_IRQ_BLK] = 1'b1;
              n.secCnt = remNext[7:0];
              n.xferSecs = blockFor(q.multi, q.blkSize, remNext);
              n.secIdx = '0;
              n.wordCnt = '0;
              n.st = ata_write_pkg::ST_XFER;
            end
          end
        end
      end
      default: begin
        n.st = ata_write_pkg::ST_IDLE;
      end
    endcase

    // ------------------------------------------------------------
    // interrupts: a new event beats a clear in the same cycle
    // ------------------------------------------------------------
    n.irqSt = (q.irqSt & ~irqClr) | irqSet;
    n.intrq = |(n.irqSt & n.irqMask);

    // ------------------------------------------------------------
    // read port, data valid only the cycle after the strobe
    // ------------------------------------------------------------
    n.rdData = 16'h0000;
    if (regRd) begin
      case (regAddr)
        `AW_OFF_FEAT: n.rdData = {8'h00, q.errReg};
        `AW_OFF_SECCNT: n.rdData = {8'h00, q.secCnt};
        `AW_OFF_SECNUM: n.rdData = {8'h00, q.secNum};
        `AW_OFF_TRKLO: n.rdData = {8'h00, q.trkLo};
        `AW_OFF_TRKHI: n.rdData = {8'h00, q.trkHi};
        `AW_OFF_DRVHD: n.rdData = {8'h00, q.drvHd};
        `AW_OFF_CMD: begin
          n.rdData[`AW_ST_BUSY] = q.busy;
          n.rdData[`AW_ST_READY] = !q.busy;
          n.rdData[`AW_ST_DRQ] = q.drq;
          n.rdData[`AW_ST_ERR] = q.errSt;
        end
        `AW_OFF_BLKSZ: n.rdData = {7'h00, q.multEn, q.blkSize};
        `AW_OFF_IRQST: n.rdData = {13'h0000, q.irqSt};
        `AW_OFF_IRQMASK: n.rdData = {13'h0000, q.irqMask};
        default: n.rdData = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.secCnt <= `AW_SECCNT_RST;
      q.secNum <= `AW_SECNUM_RST;
      q.blkSize <= `AW_BLKSZ_RST;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign regRdData = q.rdData;
  assign intrq = q.intrq;
  assign busy = q.busy;
  assign dataReq = q.drq;
  assign mediaValid = q.mVal;
  assign mediaLast = q.mLast;
  assign mediaLba = q.mLba;
  assign mediaErase = q.mErase;

endmodule : ata_write_command_engine

`default_nettype wire

// ===== flash_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// flash side: finishes each streamed sector, fails one address
// ------------------------------------------------------------
module flash_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic mediaValid,
  input wire logic mediaLast,
  input wire logic [27:0] mediaLba,
  input wire logic [27:0] failLba,
  output logic mediaDone,
  output logic mediaErr,
  output logic [27:0] lastLba
);
  logic [3:0] waitCnt;
  initial begin
    mediaDone = 1'b0;
    mediaErr = 1'b1;
    waitCnt = 4'h0;
    lastLba = 28'h0000000;
  end
  // error line is noise outside the done pulse
  always @(posedge clk) begin
    mediaDone <= 1'b0;
    mediaErr <= ~mediaErr;
    if (mediaValid && mediaLast) begin
      waitCnt <= slow ? 4'hc : 4'h1;
      lastLba <= mediaLba;
    end else if (waitCnt == 4'h1) begin
      waitCnt <= 4'h0;
      mediaDone <= 1'b1;
      mediaErr <= (lastLba == failLba);
    end else if (waitCnt != 4'h0) begin
      waitCnt <= waitCnt - 4'h1;
    end
  end
endmodule : flash_model

`default_nettype wire

// ===== ata_write_command_engine_properties.sv
`include "ata_write_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ata_write_command_engine_properties #(
  parameter int MAX_BLOCK = 8,
  parameter int WORDS_PER_SECTOR = 256
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  input wire logic busy,
  input wire logic dataReq,
  input wire logic intrq,
  input wire logic mediaValid,
  input wire logic mediaLast,
  input wire logic mediaErase,
  input wire logic mediaDone,
  input wire logic mediaErr
);
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic [15:0] wordCnt_ff;
  logic [7:0] lastCmd_ff;
  logic maskBlk_ff;
  logic blkOn_ff;
  logic cmdWr;
  localparam int BSY_CYC = `AW_BSY_MAX_CYC;
  assign cmdWr = regWr && regAddr == `AW_OFF_CMD && !busy && !dataReq;
  always_ff @(posedge clk) begin
    if (rst) begin
      wordCnt_ff <= 16'h0000;
      lastCmd_ff <= 8'h00;
      maskBlk_ff <= 1'b0;
      blkOn_ff <= 1'b0;
    end else begin
      if (mediaValid) wordCnt_ff <= mediaLast ? 16'h0000 : wordCnt_ff + 16'h0001;
      if (cmdWr) lastCmd_ff <= regWrData[7:0];
      if (regWr && regAddr == `AW_OFF_IRQMASK) maskBlk_ff <= regWrData[`AW_IRQ_BLK];
      if (regWr && regAddr == `AW_OFF_BLKSZ && !busy && !dataReq) begin
        blkOn_ff <= regWrData[`AW_BLK_EN] && regWrData[7:0] != 8'h00 &&
                    regWrData[7:0] <= 8'(MAX_BLOCK);
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sectorCmd;
    cmdWr && regWrData[7:0] inside {`AW_CMD_WRSEC_A, `AW_CMD_WRSEC_B, `AW_CMD_WRSEC_NE};
  endsequence
  sequence multiCmd;
    cmdWr && blkOn_ff && regWrData[7:0] inside {`AW_CMD_WRMULT, `AW_CMD_WRMULT_NE};
  endsequence
  sequence busyThenReq;
    busy ##1 (!busy && dataReq);
  endsequence
  chk_cmd_accept: assert property (sectorCmd |=> busyThenReq)
    else $error("command accept handshake wrong");
  chk_status_bits: assert property (regRd && regAddr == `AW_OFF_CMD |=>
    regRdData[7] == $past(busy) && regRdData[3] == $past(dataReq))
    else $error("status bits differ from handshake");
  chk_busy_excl: assert property (!(busy && dataReq))
    else $error("busy and data request together");
  chk_drq_hold: assert property (dataReq && !(regWr && regAddr == `AW_OFF_DATA) |=> dataReq)
    else $error("data request dropped without data");
  chk_media_busy: assert property (mediaValid |-> busy && !dataReq)
    else $error("media write while not busy");
  chk_err_stop: assert property (mediaDone && mediaErr |=> !busy && !dataReq ##1 !mediaValid)
    else $error("write went on after failure");
  chk_sector_len: assert property (mediaValid |->
    mediaLast == (wordCnt_ff == 16'(WORDS_PER_SECTOR - 1)))
    else $error("sector length wrong");
  chk_erase_code: assert property (mediaValid |-> mediaErase ==
    (lastCmd_ff inside {`AW_CMD_WRSEC_A, `AW_CMD_WRSEC_B, `AW_CMD_WRMULT}))
    else $error("erase flag wrong for command");
  chk_block_intr: assert property ($rose(dataReq) && $past(mediaDone) && maskBlk_ff |-> intrq)
    else $error("block start without interrupt");
  chk_multi_busy: assert property (multiCmd |-> ##[1:BSY_CYC] busy)
    else $error("busy late after block write command");
endmodule : ata_write_command_engine_properties

bind ata_write_command_engine ata_write_command_engine_properties #(
  .MAX_BLOCK(MAX_BLOCK), .WORDS_PER_SECTOR(WORDS_PER_SECTOR)) u_props (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .busy(busy), .dataReq(dataReq), .intrq(intrq),
  .mediaValid(mediaValid), .mediaLast(mediaLast), .mediaErase(mediaErase),
  .mediaDone(mediaDone), .mediaErr(mediaErr));

`default_nettype wire

// ===== ata_write_command_engine_bench.sv
`include "ata_write_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ata_write_command_engine_bench;
  localparam int WPS = 4;
  localparam logic [27:0] BASE = 28'h5332210;
  logic clk, rst, regWr, regRd, slow, intrq, busy, dataReq;
  logic mediaValid, mediaLast, mediaErase, mediaDone, mediaErr;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, rdVal, mediaData;
  logic [27:0] mediaLba, failLba, lastLba;
  int error_cnt, check_count, cyc;
  int wordSeq, mediaSeq;

  ata_write_command_engine #(.MAX_BLOCK(8), .WORDS_PER_SECTOR(WPS)) u_dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .intrq(intrq), .busy(busy), .dataReq(dataReq),
    .mediaValid(mediaValid), .mediaData(mediaData), .mediaLast(mediaLast),
    .mediaLba(mediaLba), .mediaErase(mediaErase), .mediaDone(mediaDone),
    .mediaErr(mediaErr));
  flash_model u_flash (.clk(clk), .slow(slow), .mediaValid(mediaValid),
    .mediaLast(mediaLast), .mediaLba(mediaLba), .failLba(failLba),
    .mediaDone(mediaDone), .mediaErr(mediaErr), .lastLba(lastLba));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // bus access and checking
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [27:0] exp, input logic [27:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
  endtask : rd
  task automatic waitFree();
    int n;
    n = 0;
    #1;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4000) chk("busy wait", 28'h0, 28'h1);
  endtask : waitFree
  task automatic aborted(input logic [7:0] code);
    wr(`AW_OFF_CMD, {8'h00, code});
    rd(`AW_OFF_CMD);
    chk("abort status", 28'h01, rdVal & 16'h0089);
    rd(`AW_OFF_FEAT);
    chk("abort error", 28'h04, rdVal & 16'h0004);
    chk("abort intr", 28'h1, intrq);
    wr(`AW_OFF_IRQST, 16'h0007);
    rd(`AW_OFF_IRQST);
    chk("irq clear", 28'h0, rdVal & 16'h0007);
    chk("intr clear", 28'h0, intrq);
  endtask : aborted
  task automatic xfer(input logic [7:0] code, input int cnt, bs, failAt, blocks);
    int left, blk, k, idx, expLeft;
    left = cnt;
    k = 0;
    idx = (failAt < cnt) ? failAt : cnt - 1;
    expLeft = (failAt < cnt) ? cnt - failAt : 0;
    failLba <= (failAt < cnt) ? BASE + 28'(failAt) : '1;
    wr(`AW_OFF_SECCNT, 16'(cnt[7:0]));
    wr(`AW_OFF_SECNUM, 16'(BASE[7:0]));
    wr(`AW_OFF_TRKLO, 16'(BASE[15:8]));
    wr(`AW_OFF_TRKHI, 16'(BASE[23:16]));
    wr(`AW_OFF_DRVHD, {12'h00e, BASE[27:24]});
    wr(`AW_OFF_CMD, {8'h00, code});
    waitFree();
    while (dataReq === 1'b1) begin
      rd(`AW_OFF_IRQST);
      chk("block irq", 28'(k > 0), rdVal[0]);
      chk("block intr", 28'(k > 0), intrq);
      wr(`AW_OFF_IRQST, 16'h0001);
      blk = (left < bs) ? left : bs;
      repeat (blk * WPS) begin
        wr(`AW_OFF_DATA, wordSeq[15:0]);
        wordSeq++;
      end
      left -= blk;
      k++;
      waitFree();
    end
    chk("blocks", 28'(blocks), 28'(k));
    rd(`AW_OFF_SECCNT);
    chk("left count", 28'(expLeft), rdVal);
    rd(`AW_OFF_SECNUM);
    chk("sector addr", 28'(BASE[7:0] + idx) & 28'hff, rdVal);
    chk("media lba", BASE + 28'(idx), lastLba);
    rd(`AW_OFF_IRQST);
    chk("end irq", (failAt < cnt) ? 28'h4 : 28'h2, rdVal & 16'h0006);
    wr(`AW_OFF_IRQST, 16'h0007);
  endtask : xfer
  task automatic report_and_stop();
    $display("TB: %0d checks, %0d errors", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // media words in write order; a failed block skips its rest
  always @(posedge clk) begin
    if (mediaValid === 1'b1) begin
      chk("media data", 28'(mediaSeq[15:0]), 28'(mediaData));
      mediaSeq++;
    end else if (mediaDone === 1'b1 && mediaErr === 1'b1) begin
      mediaSeq = wordSeq;
    end
  end
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    slow = 1'b0;
    failLba = '1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(`AW_OFF_SECCNT);
    chk("count reset", 28'h01, rdVal);
    rd(`AW_OFF_SECNUM);
    chk("sector reset", 28'h01, rdVal);
    rd(4'hf);
    chk("unmapped", 28'h0, rdVal);
    wr(`AW_OFF_IRQMASK, 16'h0007);
    aborted(`AW_CMD_WRMULT);
    xfer(`AW_CMD_WRSEC_A, 2, 1, 99, 2);
    xfer(`AW_CMD_WRSEC_B, 1, 1, 99, 1);
    xfer(`AW_CMD_WRSEC_NE, 3, 1, 1, 2);
    wr(`AW_OFF_BLKSZ, 16'h0002);
    aborted(`AW_CMD_WRMULT_NE);
    wr(`AW_OFF_BLKSZ, 16'h0101);
    xfer(`AW_CMD_WRMULT, 2, 1, 99, 2);
    wr(`AW_OFF_BLKSZ, 16'h0102);
    xfer(`AW_CMD_WRMULT, 5, 2, 99, 3);
    xfer(`AW_CMD_WRMULT_NE, 3, 2, 99, 2);
    wr(`AW_OFF_BLKSZ, 16'h0104);
    slow <= 1'b1;
    xfer(`AW_CMD_WRMULT, 8, 4, 2, 1);
    slow <= 1'b0;
    xfer(`AW_CMD_WRSEC_A, 256, 1, 999, 256);
    report_and_stop();
  end
endmodule : ata_write_command_engine_bench

`default_nettype wire
